// >>> hdl/pst_consts.svh
// Constants for the program space table access block
`ifndef PST_CONSTS_SVH
`define PST_CONSTS_SVH
`define PST_PW         24
`define PST_DW         16
`define PST_AW         24
`define PST_PAGE_W     8
`define PST_CFG_BIT    7
`define PST_PC_INC     23'h000002
`define PST_ZERO8      8'h00
`define PST_ZERO16     16'h0000
`define PST_ZERO24     24'h000000
`define PST_PSV_PAGE_R 8'h00
`endif

// >>> hdl/pst_pkg.sv
// Types for the program space table access block
package pst_pkg;
	typedef enum logic [2:0] {
		PST_OP_NONE,
		PST_OP_RD_LOW,
		PST_OP_RD_HIGH,
		PST_OP_WR_LOW,
		PST_OP_WR_HIGH
	} pst_op_e;
	typedef enum logic [1:0] {
		PST_IDLE,
		PST_WAIT
	} pst_state_e;
endpackage

// >>> hdl/pst_mem_if.sv
// Program memory request and answer carrier
`timescale 1ns/1ps
`include "pst_consts.svh"
interface pst_mem_if;
	logic                 req;
	logic                 wr;
	logic                 wr_low;
	logic                 wr_high;
	logic                 byte_mode;
	logic                 byte_sel;
	logic [`PST_AW-1:0]   addr;
	logic [`PST_DW-1:0]   wdata;
	logic [`PST_PW-1:0]   rdata;
	logic                 rvalid;
	modport core (output req, wr, wr_low, wr_high, byte_mode, byte_sel, addr, wdata,
		input rdata, rvalid);
	modport lane (input req, wr, wr_low, wr_high, byte_mode, byte_sel, addr, wdata,
		output rdata, rvalid);
endinterface

// >>> hdl/pst_lane.sv
// Lane steering of a program word onto the 16-bit data bus
`timescale 1ns/1ps
`include "pst_consts.svh"
module pst_lane
	import pst_pkg::*;
(
	// Request side
	pst_mem_if.lane       m,
	// Program memory side
	input  wire logic [`PST_PW-1:0] pm_rdata,
	input  wire logic               pm_rvalid,
	input  wire logic               high_sel
);
	// Pick the data lane from the program word
	function automatic logic [`PST_DW-1:0] steer(input logic [`PST_PW-1:0] w,
		input logic hi, input logic bm, input logic bs);
		logic [`PST_DW-1:0] r;
		r = `PST_ZERO16;
		if (!hi) begin
			if (!bm) begin
				r = w[15:0];
			end else begin
				r = {`PST_ZERO8, bs ? w[15:8] : w[7:0]};
			end
		end else begin
			if (!bm) begin
				r = {`PST_ZERO8, w[23:16]};
			end else begin
				r = {`PST_ZERO8, bs ? `PST_ZERO8 : w[23:16]};
			end
		end
		return r;
	endfunction

	// Steered word returned in the low bits, upper byte cleared
	assign m.rdata  = {`PST_ZERO8, steer(pm_rdata, high_sel, m.byte_mode, m.byte_sel)};
	assign m.rvalid = pm_rvalid;
endmodule

// >>> hdl/pst_table_access.sv
// Table access path between data space and program memory
`timescale 1ns/1ps
`include "pst_consts.svh"
module pst_table_access
	import pst_pkg::*;
(
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst_b,
	// Core table request
	input  wire logic                   tbl_req,
	input  wire logic [2:0]             tbl_op,
	input  wire logic                   tbl_byte_mode,
	input  wire logic [`PST_DW-1:0]     data_effective_address,
	input  wire logic [`PST_DW-1:0]     tbl_wdata,
	input  wire logic                   page_wr,
	input  wire logic [`PST_PAGE_W-1:0] page_wdata,
	output logic [`PST_PAGE_W-1:0]      table_page_register,
	output logic [`PST_DW-1:0]          tbl_rdata,
	output logic                        tbl_done,
	output logic                        tbl_cfg_space,
	// Instruction fetch
	input  wire logic                   pc_step,
	input  wire logic                   pc_load,
	input  wire logic [`PST_AW-2:0]     pc_load_val,
	output logic [`PST_AW-1:0]          fetch_addr,
	// Visibility window
	input  wire logic                   psv_req,
	input  wire logic                   psv_wr,
	input  wire logic [`PST_DW-1:0]     psv_addr,
	output logic [`PST_DW-1:0]          psv_rdata,
	output logic                        psv_done,
	// Program memory
	output logic                        pm_req,
	output logic                        pm_wr_low,
	output logic                        pm_wr_high,
	output logic [`PST_AW-1:0]          pm_addr,
	output logic [`PST_DW-1:0]          pm_wdata,
	output logic                        pm_byte_mode,
	output logic                        pm_byte_sel,
	input  wire logic [`PST_PW-1:0]     pm_rdata,
	input  wire logic                   pm_rvalid
);
	// Sequencer state, lane choice, window flag and program counter
	pst_mem_if  mi ();
	pst_state_e st_q;
	logic       hi_q;
	logic       psv_q;
	logic [`PST_AW-2:0] pc_q;
	logic [`PST_AW-1:0] tbl_addr;
	logic               byte_sel_w;

	// Read operations go out to memory and wait for the answer
	function automatic logic op_is_read(input logic [2:0] op);
		return (op == PST_OP_RD_LOW) || (op == PST_OP_RD_HIGH);
	endfunction

	// Only the high operations reach the upper byte lane
	function automatic logic op_is_high(input logic [2:0] op);
		return (op == PST_OP_RD_HIGH) || (op == PST_OP_WR_HIGH);
	endfunction

	// Byte select is the lowest effective address bit
	assign byte_sel_w = data_effective_address[0];

	// Table address from page over effective address, no alignment check
	assign tbl_addr = {table_page_register, data_effective_address};

	// Carrier view of the outgoing request for the lane steering
	assign mi.req       = pm_req;
	assign mi.wr        = pm_wr_low | pm_wr_high;
	assign mi.wr_low    = pm_wr_low;
	assign mi.wr_high   = pm_wr_high;
	assign mi.byte_mode = pm_byte_mode;
	assign mi.byte_sel  = pm_byte_sel;
	assign mi.addr      = pm_addr;
	assign mi.wdata     = pm_wdata;

	pst_lane u_lane (
		.m         (mi.lane),
		.pm_rdata  (pm_rdata),
		.pm_rvalid (pm_rvalid),
		.high_sel  (hi_q)
	);

	// Page register and its space flag
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			table_page_register <= `PST_ZERO8;
			tbl_cfg_space       <= 1'b0;
		end else if (page_wr) begin
			table_page_register <= page_wdata;
			tbl_cfg_space       <= page_wdata[`PST_CFG_BIT];
		end
	end

	// Program counter, two data addresses per program word
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pc_q <= 23'h000000;
		end else if (pc_load) begin
			pc_q <= {pc_load_val[22:1], 1'b0};
		end else if (pc_step) begin
			pc_q <= pc_q + `PST_PC_INC;
		end
	end

	// Fetch address one cycle behind the counter, top and bottom bits low
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			fetch_addr <= `PST_ZERO24;
		end else begin
			fetch_addr <= {1'b0, pc_q[22:1], 1'b0};
		end
	end

	// Request sequencer for table and visibility accesses
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q         <= PST_IDLE;
			hi_q         <= 1'b0;
			psv_q        <= 1'b0;
			pm_req       <= 1'b0;
			pm_wr_low    <= 1'b0;
			pm_wr_high   <= 1'b0;
			pm_addr      <= `PST_ZERO24;
			pm_wdata     <= `PST_ZERO16;
			pm_byte_mode <= 1'b0;
			pm_byte_sel  <= 1'b0;
			tbl_done     <= 1'b0;
			psv_done     <= 1'b0;
		end else begin
			// Strobes and done pulses last one cycle
			tbl_done   <= 1'b0;
			psv_done   <= 1'b0;
			pm_req     <= 1'b0;
			pm_wr_low  <= 1'b0;
			pm_wr_high <= 1'b0;
			case (st_q)
				PST_IDLE: begin
					if (tbl_req) begin
						// Reads permitted in either space
						pm_addr      <= tbl_addr;
						pm_byte_mode <= tbl_byte_mode;
						pm_byte_sel  <= byte_sel_w;
						pm_wdata     <= tbl_wdata;
						psv_q        <= 1'b0;
						// High ops alone reach the upper byte lane
						hi_q <= op_is_high(tbl_op);
						// Write data is already on the bus, so writes finish at once
						if (tbl_op == PST_OP_WR_LOW) begin
							pm_wr_low <= 1'b1;
							tbl_done  <= 1'b1;
						end else if (tbl_op == PST_OP_WR_HIGH) begin
							pm_wr_high <= 1'b1;
							tbl_done   <= 1'b1;
						end else if (op_is_read(tbl_op)) begin
							pm_req <= 1'b1;
							st_q   <= PST_WAIT;
						end else begin
							tbl_done <= 1'b1;
						end
					end else if (psv_req) begin
						if (psv_wr) begin
							psv_done <= 1'b1;
						end else begin
							pm_addr      <= {`PST_PSV_PAGE_R, psv_addr};
							pm_byte_mode <= 1'b0;
							pm_byte_sel  <= 1'b0;
							hi_q         <= 1'b0;
							psv_q        <= 1'b1;
							pm_req       <= 1'b1;
							st_q         <= PST_WAIT;
						end
					end
				end
				PST_WAIT: begin
					// Answer from memory ends the wait
					if (mi.rvalid) begin
						if (psv_q) begin
							psv_done <= 1'b1;
						end else begin
							tbl_done <= 1'b1;
						end
						st_q <= PST_IDLE;
					end
				end
				default: begin
					st_q <= PST_IDLE;
				end
			endcase
		end
	end

	// Read results, each held until the next answer of its own kind
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tbl_rdata <= `PST_ZERO16;
			psv_rdata <= `PST_ZERO16;
		end else if (st_q == PST_WAIT && mi.rvalid) begin
			if (psv_q) begin
				psv_rdata <= mi.rdata[`PST_DW-1:0];
			end else begin
				tbl_rdata <= mi.rdata[`PST_DW-1:0];
			end
		end
	end
endmodule

// >>> verification/pst_table_access_properties.sv
// Port checker for the table access block
`timescale 1ns/1ps
`include "pst_consts.svh"
module pst_table_access_properties (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst_b,
	// Requests and answers
	input wire logic        tbl_req, tbl_done, tbl_cfg_space, page_wr, pc_step, pc_load,
	input wire logic        psv_req, psv_wr, psv_done, pm_req, pm_wr_low, pm_wr_high, pm_rvalid,
	input wire logic [2:0]  tbl_op,
	input wire logic [7:0]  page_wdata, table_page_register,
	input wire logic [15:0] data_effective_address, tbl_wdata, pm_wdata, psv_addr,
	input wire logic [22:0] pc_load_val,
	input wire logic [23:0] fetch_addr, pm_addr
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// Busy from the memory request to its answer; requests there are ignored
	logic wait_q;
	logic idle;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= (pm_req || wait_q) && !pm_rvalid;
		end
	end
	assign idle = !pm_req && !wait_q;
	// Read taken, then memory asked
	sequence s_rd;
		idle && tbl_req && (tbl_op == 3'h1 || tbl_op == 3'h2) ##1 pm_req;
	endsequence
	property p_page; page_wr |=> table_page_register == $past(page_wdata); endproperty
	a_page: assert property (p_page) else $error("page load");
	property p_cfg; page_wr |=> tbl_cfg_space == $past(page_wdata[7]); endproperty
	a_cfg: assert property (p_cfg) else $error("space select");
	property p_fetch;
		pc_load |=> ##1 fetch_addr == {1'b0, $past(pc_load_val[22:1], 2), 1'b0};
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch address");
	property p_step;
		(pc_step && !pc_load) ##1 !(pc_step || pc_load) |=> fetch_addr == $past(fetch_addr) + 24'h2;
	endproperty
	a_step: assert property (p_step) else $error("pc step");
	property p_wr_low;
		idle && tbl_req && tbl_op == 3'h3 |=>
			pm_wr_low && !pm_wr_high && pm_wdata == $past(tbl_wdata);
	endproperty
	a_wr_low: assert property (p_wr_low) else $error("low write");
	property p_wr_high;
		idle && tbl_req && tbl_op == 3'h4 |=> pm_wr_high && !pm_wr_low;
	endproperty
	a_wr_high: assert property (p_wr_high) else $error("high write");
	property p_psv_wr;
		idle && psv_req && psv_wr && !tbl_req |=>
			psv_done && !(pm_req || pm_wr_low || pm_wr_high);
	endproperty
	a_psv_wr: assert property (p_psv_wr) else $error("window write");
	property p_psv_rd;
		idle && psv_req && !psv_wr && !tbl_req |=> pm_req && !pm_wr_low && !pm_wr_high
			&& pm_addr == {`PST_PSV_PAGE_R, $past(psv_addr)};
	endproperty
	a_psv_rd: assert property (p_psv_rd) else $error("window read");
	property p_addr; s_rd |-> pm_addr == {table_page_register, $past(data_effective_address)}; endproperty
	a_addr: assert property (p_addr) else $error("table address");
	property p_rd; s_rd |-> ##[1:8] pm_rvalid ##1 tbl_done; endproperty
	a_rd: assert property (p_rd) else $error("read done");
endmodule
bind pst_table_access pst_table_access_properties chk_u (.core_clk, .rst_b, .tbl_req, .tbl_done,
	.tbl_cfg_space, .page_wr, .pc_step, .pc_load, .psv_req, .psv_wr, .psv_done, .pm_req, .pm_wr_low,
	.pm_wr_high, .pm_rvalid, .tbl_op, .page_wdata, .table_page_register, .data_effective_address,
	.tbl_wdata, .pm_wdata, .psv_addr, .pc_load_val, .fetch_addr, .pm_addr);

// >>> verification/pst_mem_model.sv
// Program memory model with adjustable answer latency
`timescale 1ns/1ps
module pst_mem_model (
	input  wire logic        core_clk,
	input  wire logic        pm_req,
	input  wire logic [23:0] pm_addr,
	input  wire logic [1:0]  lag,
	output logic      [23:0] pm_rdata,
	output logic             pm_rvalid
);
	logic [1:0] cnt_q;
	logic       busy_q = 1'b0;
	initial pm_rdata = 24'h000000;
	initial pm_rvalid = 1'b0;
	// Answer a 24-bit word lag+1 cycles after the request; data garbles outside the answer
	always @(posedge core_clk) begin
		pm_rvalid <= 1'b0;
		pm_rdata <= ~pm_rdata;
		if (pm_req) begin
			busy_q <= 1'b1;
			cnt_q <= lag;
		end else if (busy_q && cnt_q != 2'h0) begin
			cnt_q <= cnt_q - 2'h1;
		end else if (busy_q) begin
			busy_q <= 1'b0;
			pm_rvalid <= 1'b1;
			pm_rdata <= {pm_addr[7:0], ~pm_addr[15:0]};
		end
	end
endmodule

// >>> verification/pst_table_access_bench.sv
// Self-checking bench for the table access block
`timescale 1ns/1ps
`include "pst_consts.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module pst_table_access_bench;
	logic        core_clk = 0, rst_b = 0, tbl_req = 0, tbl_byte_mode = 0, page_wr = 0;
	logic        pc_step = 0, pc_load = 0, psv_req = 0, psv_wr = 0, tbl_done, tbl_cfg_space;
	logic        psv_done, pm_req, pm_wr_low, pm_wr_high, pm_byte_mode, pm_byte_sel, pm_rvalid;
	logic [1:0]  lag = 0;
	logic [2:0]  tbl_op = 0;
	logic [7:0]  page_wdata = 0, table_page_register;
	logic [15:0] data_effective_address = 0, tbl_wdata = 0, psv_addr = 0;
	logic [15:0] tbl_rdata, psv_rdata, pm_wdata;
	logic [22:0] pc_load_val = 0;
	logic [23:0] fetch_addr, pm_addr, pm_rdata;
	int          fail_count = 0, checks_done = 0;
	pst_table_access dut_u (.core_clk, .rst_b, .tbl_req, .tbl_op, .tbl_byte_mode,
		.data_effective_address, .tbl_wdata, .page_wr, .page_wdata, .table_page_register,
		.tbl_rdata, .tbl_done, .tbl_cfg_space, .pc_step, .pc_load, .pc_load_val, .fetch_addr,
		.psv_req, .psv_wr, .psv_addr, .psv_rdata, .psv_done, .pm_req, .pm_wr_low, .pm_wr_high,
		.pm_addr, .pm_wdata, .pm_byte_mode, .pm_byte_sel, .pm_rdata, .pm_rvalid);
	pst_mem_model mem_u (.core_clk, .pm_req, .pm_addr, .lag, .pm_rdata, .pm_rvalid);
	// 100 MHz core clock
	initial forever #5 core_clk = ~core_clk;
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// One table request, held for one edge, then wait for completion
	task automatic tbl(input logic [2:0] o, input logic bm, input logic [15:0] a);
		@(posedge core_clk) #1;
		{tbl_req, tbl_op, tbl_byte_mode, data_effective_address, tbl_wdata} = {1'b1, o, bm, a, ~a};
		@(posedge core_clk) #1;
		tbl_req = 0;
		for (int i = 0; i < 20 && tbl_done !== 1'b1; i++) @(posedge core_clk) #1;
		`CHK(tbl_done, 1'b1)
	endtask
	// Load the page register
	task automatic page(input logic [7:0] v);
		@(posedge core_clk) #1;
		{page_wr, page_wdata} = {1'b1, v};
		@(posedge core_clk) #1;
		page_wr = 0;
		`CHK(tbl_cfg_space, v[7])
	endtask
	// Every read kind, size and byte select, odd addresses, slow memory
	task automatic t_reads(input logic [7:0] pg);
		logic [15:0] a, got;
		logic [23:0] p;
		for (int k = 0; k < 8; k++) begin
			a = 16'h2468 ^ 16'(k);
			p = {a[7:0], ~a};
			lag = 2'(k);
			tbl(k[2] ? 3'h2 : 3'h1, k[1], a);
			`CHK(pm_addr, {pg, a})
			`CHK(pm_byte_sel, a[0])
			got = k[1] ? {8'h00, tbl_rdata[7:0]} : tbl_rdata;
			if (k[2]) `CHK(got, (k[1] && a[0]) ? 16'h0000 : {8'h00, p[23:16]})
			else `CHK(got, k[1] ? {8'h00, a[0] ? p[15:8] : p[7:0]} : p[15:0])
		end
	endtask
	// Low and high writes in both sizes
	task automatic t_writes;
		for (int k = 0; k < 4; k++) begin
			tbl(k[1] ? 3'h4 : 3'h3, k[0], 16'h1357 + 16'(k));
			`CHK(pm_wdata, ~(16'h1357 + 16'(k)))
			`CHK(pm_byte_mode, k[0])
			`CHK({pm_wr_high, pm_wr_low}, k[1] ? 2'b10 : 2'b01)
		end
	endtask
	// Load the program counter, then step it once
	task automatic t_fetch;
		@(posedge core_clk) #1;
		{pc_load, pc_load_val} = {1'b1, 23'h400003};
		@(posedge core_clk) #1;
		{pc_load, pc_step} = 2'b01;
		@(posedge core_clk) #1;
		pc_step = 0;
		`CHK(fetch_addr, 24'h400002)
		@(posedge core_clk) #1;
		`CHK(fetch_addr, 24'h400004)
	endtask
	// Window read, write, read again
	task automatic t_psv;
		for (int j = 0; j < 3; j++) begin
			@(posedge core_clk) #1;
			{psv_req, psv_wr, psv_addr} = {1'b1, j == 1, 16'h8ACE + 16'(j)};
			@(posedge core_clk) #1;
			psv_req = 0;
			for (int i = 0; i < 20 && psv_done !== 1'b1; i++) @(posedge core_clk) #1;
			`CHK(psv_done, 1'b1)
			`CHK(psv_rdata, (j == 1) ? 16'h7531 : ~(16'h8ACE + 16'(j)))
		end
	endtask
	// Reset for ten cycles, then each scenario in turn
	initial begin
		repeat (10) @(posedge core_clk);
		#1 rst_b = 1;
		page(8'h12);
		t_reads(8'h12);
		page(8'h85);
		t_reads(8'h85);
		t_writes;
		t_fetch;
		t_psv;
		final_report;
	end
	// Watchdog far beyond the expected run
	initial begin
		#100000;
		fail_count++;
		final_report;
	end
endmodule
